// File: pkg/fault_monitor_pkg.sv
// constants and types shared by the fieldbus fault monitor
package fault_monitor_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS   = 40;
    localparam int MODE_GAP_NS     = 2000000;
    localparam int MODE_GAP_CYCLES = (MODE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W           = 16;

    // main error numbers
    localparam logic [7:0] MAIN_STATE   = 8'h83;
    localparam logic [7:0] MAIN_NODE    = 8'h88;
    localparam logic [7:0] MAIN_SETTING = 8'h90;
    localparam logic [7:0] MAIN_CMD     = 8'h91;

    // sub error numbers
    localparam logic [7:0] SUB_NONE         = 8'h00;
    localparam logic [7:0] SUB_STATE_CHANGE = 8'h01;
    localparam logic [7:0] SUB_ILLEGAL      = 8'h02;
    localparam logic [7:0] SUB_SYNC         = 8'h03;
    localparam logic [7:0] SUB_WDT          = 8'h05;
    localparam logic [7:0] SUB_CMD          = 8'h01;

    // communication state request codes
    localparam logic [3:0] CODE_INIT   = 4'h1;
    localparam logic [3:0] CODE_PREOP  = 4'h2;
    localparam logic [3:0] CODE_BOOT   = 4'h3;
    localparam logic [3:0] CODE_SAFEOP = 4'h4;
    localparam logic [3:0] CODE_OP     = 4'h8;

    // node address switches, status word, sync cycle range
    localparam logic [3:0]  NODE_DIGIT_MAX = 4'h9;
    localparam int          REMOTE_BIT     = 9;
    localparam logic [31:0] SYNC_MIN_NS    = 32'h0003_D090;
    localparam logic [31:0] SYNC_MAX_NS    = 32'h0098_9680;

    // supported operating modes
    localparam logic [7:0] MODE_PP  = 8'h01;
    localparam logic [7:0] MODE_PV  = 8'h03;
    localparam logic [7:0] MODE_HM  = 8'h06;
    localparam logic [7:0] MODE_CSP = 8'h08;
    localparam logic [7:0] MODE_CSV = 8'h09;
    localparam logic [7:0] MODE_CST = 8'h0A;

    // supported homing methods
    localparam logic [7:0] HOME_08 = 8'h08;
    localparam logic [7:0] HOME_12 = 8'h0C;
    localparam logic [7:0] HOME_19 = 8'h13;
    localparam logic [7:0] HOME_20 = 8'h14;
    localparam logic [7:0] HOME_33 = 8'h21;
    localparam logic [7:0] HOME_34 = 8'h22;
    localparam logic [7:0] HOME_35 = 8'h23;

    typedef enum logic [1:0] {ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP} comm_state_e;

endpackage

// File: pkg/count_link_if.sv
// link between the monitor and its counting helpers
`timescale 1ns/1ps
interface count_link_if #(parameter int W = 16);
    logic         bump;
    logic         restart;
    logic [W-1:0] limit;
    logic         hit;

    modport owner  (output bump, output restart, output limit, input hit);
    modport worker (input bump, input restart, input limit, output hit);
endinterface

// File: verilog/consec_counter.sv
// counter of consecutive events with a one-cycle over-limit pulse
`timescale 1ns/1ps
module consec_counter #(
    parameter int W = 16
) (
    input  wire logic   clock_i,
    input  wire logic   reset_i,
    count_link_if.worker link
);
    logic [W-1:0] count_reg;
    logic         hit_reg;
    logic [W-1:0] count_next;

    // saturating increment, cleared by a good event
    assign count_next = (count_reg == {W{1'b1}}) ? count_reg : count_reg + 1'b1;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            count_reg <= '0;
        end else if (link.restart) begin
            count_reg <= '0;
        end else if (link.bump) begin
            count_reg <= count_next;
        end
    end

    // pulse on each event that takes the run past the limit
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            hit_reg <= 1'b0;
        end else begin
            hit_reg <= link.bump && !link.restart && (count_next > link.limit);
        end
    end

    assign link.hit = hit_reg;

    property p_hit_cause;
        @(posedge clock_i) disable iff (reset_i)
        hit_reg |-> $past(link.bump) && ($past(count_next) > $past(link.limit));
    endproperty
    a_hit_cause: assert property (p_hit_cause) else $error("over-limit pulse without cause");
endmodule

// File: verilog/gap_timer.sv
// elapsed-time counter, hit once the limit is reached
`timescale 1ns/1ps
module gap_timer #(
    parameter int W = 16
) (
    input  wire logic   clock_i,
    input  wire logic   reset_i,
    count_link_if.worker link
);
    logic [W-1:0] count_reg;

    // count while running, saturate at the limit
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            count_reg <= '0;
        end else if (link.restart) begin
            count_reg <= '0;
        end else if (link.bump && (count_reg < link.limit)) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    assign link.hit = (count_reg >= link.limit);

    property p_no_overrun;
        @(posedge clock_i) disable iff (reset_i)
        (link.bump && !link.restart && link.hit && $stable(link.limit)) |=> $stable(count_reg);
    endproperty
    a_no_overrun: assert property (p_no_overrun) else $error("timer ran past its limit");
endmodule

// File: verilog/fieldbus_fault_monitor.sv
// fieldbus slave fault detection and error number reporting
//
// How it works
// - state request not reachable from current state reports 83.1
// - state request with undefined code reports 83.2
// - consecutive sync-period receive failures beyond configured limit report 83.3
// - process data silent longer than watchdog period reports 83.5
// - node address switches outside 00..99 at power-on report 88.0
// - out-of-range sync cycle setting written reports 90.0
// - request for unsupported state reports 90.0
// - leaving operational while remote and enabled reports 91.1
// - unsupported operating mode written reports 91.1
// - operating mode changed again within 2 ms reports 91.1
// - homing started with unsupported method reports 91.1
// - consecutive data-setting warnings beyond configured limit report 91.1
`timescale 1ns/1ps
module fieldbus_fault_monitor
    import fault_monitor_pkg::*;
#(
    parameter int GAP_CYCLES = MODE_GAP_CYCLES
) (
    input  wire logic              clock_i,
    input  wire logic              reset_i,
    input  wire logic              state_cmd_valid_i,
    input  wire logic [3:0]        state_cmd_i,
    input  wire logic              pdo_rx_i,
    input  wire logic              sync_event_i,
    input  wire logic [CNT_W-1:0]  comm_err_limit_i,
    input  wire logic [CNT_W-1:0]  wdt_period_i,
    input  wire logic [3:0]        node_tens_i,
    input  wire logic [3:0]        node_ones_i,
    input  wire logic              sync_cycle_wr_i,
    input  wire logic [31:0]       sync_cycle_ns_i,
    input  wire logic [15:0]       status_word_i,
    input  wire logic              op_enabled_i,
    input  wire logic              mode_wr_i,
    input  wire logic [7:0]        mode_val_i,
    input  wire logic              homing_start_i,
    input  wire logic [7:0]        homing_method_i,
    input  wire logic              data_warn_i,
    input  wire logic              data_ok_i,
    input  wire logic [CNT_W-1:0]  warn_limit_i,
    input  wire logic              error_clear_i,
    output logic                   error_active_o,
    output logic [7:0]             error_main_o,
    output logic [7:0]             error_sub_o,
    output logic [3:0]             comm_state_o
);

    comm_state_e state_reg;
    comm_state_e state_next;
    logic        por_done_reg;
    logic        rx_seen_reg;
    logic        wdt_armed_reg;
    logic        mode_seen_reg;
    logic [7:0]  mode_reg;
    logic        cmd_defined;
    logic        cmd_allowed;
    logic        remote_lock;
    logic        f_node;
    logic        f_undef;
    logic        f_unsup;
    logic        f_remote;
    logic        f_trans;
    logic        f_setting;
    logic        f_sync;
    logic        f_wdt;
    logic        f_mode;
    logic        f_gap;
    logic        f_home;
    logic        f_warn;
    logic        mode_change;
    logic        fault_any;
    logic [7:0]  fault_main;
    logic [7:0]  fault_sub;

    count_link_if #(.W(CNT_W)) sync_link ();
    count_link_if #(.W(CNT_W)) wdt_link ();
    count_link_if #(.W(CNT_W)) gap_link ();
    count_link_if #(.W(CNT_W)) warn_link ();

    // supported operating modes
    function automatic logic mode_ok(input logic [7:0] m);
        return (m == MODE_PP) || (m == MODE_PV) || (m == MODE_HM) ||
               (m == MODE_CSP) || (m == MODE_CSV) || (m == MODE_CST);
    endfunction

    // supported homing methods
    function automatic logic homing_ok(input logic [7:0] h);
        return (h == HOME_08) || (h == HOME_12) || (h == HOME_19) || (h == HOME_20) ||
               (h == HOME_33) || (h == HOME_34) || (h == HOME_35);
    endfunction

    // protocol code of the current state
    function automatic logic [3:0] state_code(input comm_state_e s);
        case (s)
            ST_INIT:   return CODE_INIT;
            ST_PREOP:  return CODE_PREOP;
            ST_SAFEOP: return CODE_SAFEOP;
            ST_OP:     return CODE_OP;
            default:   return CODE_INIT;
        endcase
    endfunction

    // decode a state request against the current state
    always_comb begin
        cmd_defined = (state_cmd_i == CODE_INIT) || (state_cmd_i == CODE_PREOP) ||
                      (state_cmd_i == CODE_BOOT) || (state_cmd_i == CODE_SAFEOP) ||
                      (state_cmd_i == CODE_OP);
        state_next  = state_reg;
        case (state_cmd_i)
            CODE_INIT:   state_next = ST_INIT;
            CODE_PREOP:  state_next = ST_PREOP;
            CODE_SAFEOP: state_next = ST_SAFEOP;
            CODE_OP:     state_next = ST_OP;
            default:     state_next = state_reg;
        endcase
        case (state_reg)
            ST_INIT:   cmd_allowed = (state_cmd_i == CODE_INIT) || (state_cmd_i == CODE_PREOP);
            ST_PREOP:  cmd_allowed = (state_cmd_i != CODE_OP);
            ST_SAFEOP: cmd_allowed = 1'b1;
            ST_OP:     cmd_allowed = 1'b1;
            default:   cmd_allowed = 1'b0;
        endcase
        remote_lock = status_word_i[REMOTE_BIT] && op_enabled_i &&
                      (state_reg == ST_OP) && (state_cmd_i != CODE_OP);
    end

    // individual fault conditions
    assign f_node    = !por_done_reg && ((node_tens_i > NODE_DIGIT_MAX) ||
                                         (node_ones_i > NODE_DIGIT_MAX));
    assign f_undef   = state_cmd_valid_i && !cmd_defined;
    assign f_unsup   = state_cmd_valid_i && (state_cmd_i == CODE_BOOT);
    assign f_remote  = state_cmd_valid_i && cmd_defined && remote_lock;
    assign f_trans   = state_cmd_valid_i && cmd_defined && !cmd_allowed;
    assign f_setting = sync_cycle_wr_i && ((sync_cycle_ns_i < SYNC_MIN_NS) ||
                                           (sync_cycle_ns_i > SYNC_MAX_NS));
    assign f_sync    = sync_link.hit;
    assign f_wdt     = wdt_armed_reg && wdt_link.hit && (wdt_period_i != '0);
    assign mode_change = mode_wr_i && mode_ok(mode_val_i) && (mode_val_i != mode_reg);
    assign f_mode    = mode_wr_i && !mode_ok(mode_val_i);
    assign f_gap     = mode_change && mode_seen_reg && !gap_link.hit;
    assign f_home    = homing_start_i && !homing_ok(homing_method_i);
    assign f_warn    = warn_link.hit;

    // fixed priority among faults found in the same cycle
    always_comb begin
        fault_any  = 1'b1;
        fault_main = MAIN_CMD;
        fault_sub  = SUB_CMD;
        if (f_node) begin
            fault_main = MAIN_NODE;
            fault_sub  = SUB_NONE;
        end else if (f_undef) begin
            fault_main = MAIN_STATE;
            fault_sub  = SUB_ILLEGAL;
        end else if (f_unsup || f_setting) begin
            fault_main = MAIN_SETTING;
            fault_sub  = SUB_NONE;
        end else if (f_remote) begin
            fault_main = MAIN_CMD;
            fault_sub  = SUB_CMD;
        end else if (f_trans) begin
            fault_main = MAIN_STATE;
            fault_sub  = SUB_STATE_CHANGE;
        end else if (f_sync) begin
            fault_main = MAIN_STATE;
            fault_sub  = SUB_SYNC;
        end else if (f_wdt) begin
            fault_main = MAIN_STATE;
            fault_sub  = SUB_WDT;
        end else if (f_mode || f_gap || f_home || f_warn) begin
            fault_main = MAIN_CMD;
            fault_sub  = SUB_CMD;
        end else begin
            fault_any  = 1'b0;
        end
    end

    // power-on checks run in the first cycle after reset release only
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            por_done_reg <= 1'b0;
        end else begin
            por_done_reg <= 1'b1;
        end
    end

    // communication state follows accepted requests
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg <= ST_INIT;
        end else if (state_cmd_valid_i && cmd_defined && cmd_allowed && !remote_lock &&
                     (state_cmd_i != CODE_BOOT)) begin
            state_reg <= state_next;
        end
    end

    // receive seen in the current sync period; a receive beats the period end
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rx_seen_reg <= 1'b0;
        end else if (pdo_rx_i) begin
            rx_seen_reg <= !sync_event_i;
        end else if (sync_event_i) begin
            rx_seen_reg <= 1'b0;
        end
    end

    // consecutive receive failures, counted in safe-op and op only
    assign sync_link.bump    = sync_event_i && !rx_seen_reg && !pdo_rx_i &&
                               ((state_reg == ST_SAFEOP) || (state_reg == ST_OP));
    assign sync_link.restart = sync_event_i && (rx_seen_reg || pdo_rx_i);
    assign sync_link.limit   = comm_err_limit_i;

    consec_counter #(.W(CNT_W)) u_sync_count (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .link    (sync_link)
    );

    // watchdog armed by the first process data, dropped outside safe-op/op or on expiry
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            wdt_armed_reg <= 1'b0;
        end else if (f_wdt || ((state_reg != ST_SAFEOP) && (state_reg != ST_OP))) begin
            wdt_armed_reg <= 1'b0;
        end else if (pdo_rx_i) begin
            wdt_armed_reg <= 1'b1;
        end
    end

    assign wdt_link.bump    = wdt_armed_reg;
    assign wdt_link.restart = pdo_rx_i || !wdt_armed_reg;
    assign wdt_link.limit   = wdt_period_i;

    gap_timer #(.W(CNT_W)) u_wdt_timer (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .link    (wdt_link)
    );

    // last accepted operating mode and whether one was seen
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            mode_reg      <= 8'h00;
            mode_seen_reg <= 1'b0;
        end else if (mode_change) begin
            mode_reg      <= mode_val_i;
            mode_seen_reg <= 1'b1;
        end
    end

    // time since the last mode change
    assign gap_link.bump    = 1'b1;
    assign gap_link.restart = mode_change;
    assign gap_link.limit   = CNT_W'(GAP_CYCLES - 1);

    gap_timer #(.W(CNT_W)) u_gap_timer (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .link    (gap_link)
    );

    // consecutive data-setting warnings
    assign warn_link.bump    = data_warn_i;
    assign warn_link.restart = data_ok_i && !data_warn_i;
    assign warn_link.limit   = warn_limit_i;

    consec_counter #(.W(CNT_W)) u_warn_count (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .link    (warn_link)
    );

    // first fault latched; a fault in the clear cycle wins over the clear
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            error_active_o <= 1'b0;
            error_main_o   <= 8'h00;
            error_sub_o    <= 8'h00;
        end else if (fault_any && (!error_active_o || error_clear_i)) begin
            error_active_o <= 1'b1;
            error_main_o   <= fault_main;
            error_sub_o    <= fault_sub;
        end else if (error_clear_i) begin
            error_active_o <= 1'b0;
            error_main_o   <= 8'h00;
            error_sub_o    <= 8'h00;
        end
    end

    // current state code for the host
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            comm_state_o <= CODE_INIT;
        end else begin
            comm_state_o <= state_code(state_reg);
        end
    end

    // checks
    sequence s_free;
        por_done_reg && !error_active_o && !error_clear_i;
    endsequence

    sequence s_report(logic [7:0] m, logic [7:0] s);
        ##1 (error_active_o && (error_main_o == m) && (error_sub_o == s));
    endsequence

    property p_undef;
        @(posedge clock_i) disable iff (reset_i)
        (s_free and f_undef) |-> s_report(MAIN_STATE, SUB_ILLEGAL);
    endproperty
    a_undef: assert property (p_undef) else $error("undefined request not reported");

    property p_trans;
        @(posedge clock_i) disable iff (reset_i)
        (s_free and (f_trans && !f_undef && !f_unsup && !f_setting && !f_remote)) |->
            s_report(MAIN_STATE, SUB_STATE_CHANGE);
    endproperty
    a_trans: assert property (p_trans) else $error("bad transition not reported");

    property p_node;
        @(posedge clock_i) disable iff (reset_i)
        (!reset_i && !por_done_reg && ((node_tens_i > NODE_DIGIT_MAX) || (node_ones_i > NODE_DIGIT_MAX))) |->
            s_report(MAIN_NODE, SUB_NONE);
    endproperty
    a_node: assert property (p_node) else $error("bad node address not reported");

    property p_unsup;
        @(posedge clock_i) disable iff (reset_i)
        (s_free and (f_unsup || (f_setting && !f_undef))) |-> s_report(MAIN_SETTING, SUB_NONE);
    endproperty
    a_unsup: assert property (p_unsup) else $error("setting fault not reported");

    property p_remote;
        @(posedge clock_i) disable iff (reset_i)
        (f_remote && !f_undef) |=> (state_reg == ST_OP) && (comm_state_o == CODE_OP);
    endproperty
    a_remote: assert property (p_remote) else $error("remote lock left operational");

    property p_mode;
        @(posedge clock_i) disable iff (reset_i)
        (s_free and (f_mode && !f_undef && !f_unsup && !f_setting && !f_remote && !f_trans &&
                     !f_sync && !f_wdt)) |-> s_report(MAIN_CMD, SUB_CMD);
    endproperty
    a_mode: assert property (p_mode) else $error("bad mode not reported");

    property p_gap;
        @(posedge clock_i) disable iff (reset_i)
        mode_change |=> !gap_link.hit [*8];
    endproperty
    a_gap: assert property (p_gap) else $error("mode gap window too short");

    property p_hold;
        @(posedge clock_i) disable iff (reset_i)
        (error_active_o && !error_clear_i) |=>
            error_active_o && $stable(error_main_o) && $stable(error_sub_o);
    endproperty
    a_hold: assert property (p_hold) else $error("latched error changed");

    property p_por_once;
        @(posedge clock_i) disable iff (reset_i)
        (por_done_reg && (error_main_o != MAIN_NODE)) |=> por_done_reg && (error_main_o != MAIN_NODE);
    endproperty
    a_por_once: assert property (p_por_once) else $error("power-on check repeated");

endmodule

// File: sim/host_master_model.sv
// host master model: process data frame then sync interrupt, every 8 cycles
`timescale 1ns/1ps
module host_master_model (
    input  wire logic clock_i,
    input  wire logic run_i,
    input  wire logic miss_i,
    output logic      pdo_rx_o,
    output logic      sync_event_o
);
    logic [2:0] phase_reg;

    // frames only while running; the frame lands well before the interrupt
    always_ff @(posedge clock_i) begin
        phase_reg <= run_i ? phase_reg + 3'h1 : 3'h0;
        pdo_rx_o <= run_i && !miss_i && phase_reg == 3'h2;
        sync_event_o <= run_i && phase_reg == 3'h7;
    end
endmodule

// File: sim/tb_top.sv
// self-checking bench for the fieldbus fault monitor
`timescale 1ns/1ps
module tb_top;
    import fault_monitor_pkg::*;
    localparam int GAP = 20;
    logic             clock_i = 1'b0;
    logic             reset_i = 1'b1;
    logic             state_cmd_valid_i = 1'b0, sync_cycle_wr_i = 1'b0, mode_wr_i = 1'b0;
    logic             homing_start_i = 1'b0, data_warn_i = 1'b0, data_ok_i = 1'b0, error_clear_i = 1'b0;
    logic             op_enabled_i = 1'b0, run_i = 1'b0, miss_i = 1'b0;
    logic [3:0]       state_cmd_i = 4'h0, node_tens_i = 4'hA, node_ones_i = 4'h0;
    logic [31:0]      sync_cycle_ns_i = 32'h0;
    logic [15:0]      status_word_i = 16'h0000;
    logic [7:0]       mode_val_i = 8'h00, homing_method_i = 8'h00;
    logic [CNT_W-1:0] comm_err_limit_i = 16'h0002, wdt_period_i = 16'h003C, warn_limit_i = 16'h0001;
    wire logic        pdo_rx_i, sync_event_i, error_active_o;
    wire logic [7:0]  error_main_o, error_sub_o;
    wire logic [3:0]  comm_state_o;
    int               n_errors = 0;
    int               check_count = 0;
    logic [7:0]       homes [7] = '{HOME_08, HOME_12, HOME_19, HOME_20, HOME_33, HOME_34, HOME_35};
    logic [7:0]       modes [5] = '{MODE_PV, MODE_HM, MODE_CSP, MODE_CSV, MODE_CST};

    // 25 MHz clock
    always #20 clock_i = ~clock_i;

    fieldbus_fault_monitor #(.GAP_CYCLES(GAP)) fieldbus_fault_monitor_i (
        .clock_i, .reset_i, .state_cmd_valid_i, .state_cmd_i, .pdo_rx_i, .sync_event_i,
        .comm_err_limit_i, .wdt_period_i, .node_tens_i, .node_ones_i, .sync_cycle_wr_i,
        .sync_cycle_ns_i, .status_word_i, .op_enabled_i, .mode_wr_i, .mode_val_i,
        .homing_start_i, .homing_method_i, .data_warn_i, .data_ok_i, .warn_limit_i,
        .error_clear_i, .error_active_o, .error_main_o, .error_sub_o, .comm_state_o
    );

    host_master_model host_master_model_i (
        .clock_i(clock_i), .run_i(run_i), .miss_i(miss_i),
        .pdo_rx_o(pdo_rx_i), .sync_event_o(sync_event_i)
    );

    task automatic stop_test;
        if (n_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask

    // one-cycle strobe k carrying value v
    task automatic pulse(input int k, input logic [31:0] v);
        @(posedge clock_i);
        state_cmd_i <= v[3:0];
        sync_cycle_ns_i <= v;
        mode_val_i <= v[7:0];
        homing_method_i <= v[7:0];
        case (k)
            0: state_cmd_valid_i <= 1'b1;
            1: sync_cycle_wr_i <= 1'b1;
            2: mode_wr_i <= 1'b1;
            3: homing_start_i <= 1'b1;
            4: data_warn_i <= 1'b1;
            5: data_ok_i <= 1'b1;
            default: error_clear_i <= 1'b1;
        endcase
        @(posedge clock_i);
        {state_cmd_valid_i, sync_cycle_wr_i, mode_wr_i, homing_start_i} <= 4'h0;
        {data_warn_i, data_ok_i, error_clear_i} <= 3'h0;
    endtask

    // main 00 means no fault may appear; otherwise wait, compare, clear
    task automatic expect_err(input logic [7:0] m, input logic [7:0] s);
        int i;
        i = 0;
        if (m === 8'h00) begin
            repeat (4) @(negedge clock_i);
        end else begin
            while (error_active_o !== 1'b1 && i < 100) begin
                @(negedge clock_i);
                i++;
            end
            if (i == 100) begin
                n_errors++;
                stop_test();
            end
            chk("error_main_o", m, error_main_o);
            chk("error_sub_o", s, error_sub_o);
            @(posedge clock_i);
            miss_i <= 1'b0;
            repeat (9) @(posedge clock_i);
            pulse(6, 0);
            @(negedge clock_i);
        end
        chk("error_active_o", 8'h00, {7'h00, error_active_o});
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge clock_i);
        chk("comm_state_o", 8'h01, {4'h0, comm_state_o});
        chk("error_main_o", 8'h00, error_main_o);
        reset_i <= 1'b0;
        expect_err(MAIN_NODE, SUB_NONE);
        expect_err(8'h00, 8'h00);
        pulse(0, 32'(CODE_SAFEOP));
        expect_err(MAIN_STATE, SUB_STATE_CHANGE);
        pulse(0, 32'h5);
        expect_err(MAIN_STATE, SUB_ILLEGAL);
        pulse(0, 32'(CODE_BOOT));
        expect_err(MAIN_SETTING, SUB_NONE);
        pulse(1, SYNC_MIN_NS - 32'h1);
        expect_err(MAIN_SETTING, SUB_NONE);
        pulse(1, SYNC_MAX_NS + 32'h1);
        expect_err(MAIN_SETTING, SUB_NONE);
        pulse(1, SYNC_MIN_NS);
        expect_err(8'h00, 8'h00);
        pulse(2, 32'h2);
        expect_err(MAIN_CMD, SUB_CMD);
        pulse(2, 32'(MODE_PP));
        pulse(2, 32'(MODE_PV));
        expect_err(MAIN_CMD, SUB_CMD);
        for (int j = 0; j < 5; j++) begin
            repeat (GAP + 2) @(posedge clock_i);
            pulse(2, 32'(modes[j]));
            expect_err(8'h00, 8'h00);
        end
        // change exactly one gap apart is legal, one cycle sooner is not
        repeat (GAP + 2) @(posedge clock_i);
        pulse(2, 32'(MODE_PV));
        repeat (GAP - 2) @(posedge clock_i);
        pulse(2, 32'(MODE_HM));
        expect_err(8'h00, 8'h00);
        repeat (GAP + 2) @(posedge clock_i);
        pulse(2, 32'(MODE_CSP));
        repeat (GAP - 3) @(posedge clock_i);
        pulse(2, 32'(MODE_PV));
        expect_err(MAIN_CMD, SUB_CMD);
        pulse(3, 32'h7);
        expect_err(MAIN_CMD, SUB_CMD);
        for (int j = 0; j < 7; j++) begin
            pulse(3, 32'(homes[j]));
            expect_err(8'h00, 8'h00);
        end
        pulse(4, 0);
        pulse(5, 0);
        pulse(4, 0);
        expect_err(8'h00, 8'h00);
        pulse(4, 0);
        expect_err(MAIN_CMD, SUB_CMD);
        pulse(5, 0);
        pulse(0, 32'h5);
        pulse(3, 32'h7);
        expect_err(MAIN_STATE, SUB_ILLEGAL);
        @(posedge clock_i);
        run_i <= 1'b1;
        pulse(0, 32'(CODE_PREOP));
        pulse(0, 32'(CODE_SAFEOP));
        pulse(0, 32'(CODE_OP));
        expect_err(8'h00, 8'h00);
        chk("comm_state_o", 8'h08, {4'h0, comm_state_o});
        @(posedge clock_i);
        status_word_i <= 16'h0200;
        op_enabled_i <= 1'b1;
        pulse(0, 32'(CODE_PREOP));
        expect_err(MAIN_CMD, SUB_CMD);
        chk("comm_state_o", 8'h08, {4'h0, comm_state_o});
        @(posedge clock_i);
        status_word_i <= 16'h0000;
        pulse(0, 32'(CODE_SAFEOP));
        expect_err(8'h00, 8'h00);
        chk("comm_state_o", 8'h04, {4'h0, comm_state_o});
        @(posedge clock_i);
        miss_i <= 1'b1;
        expect_err(MAIN_STATE, SUB_SYNC);
        @(posedge clock_i);
        run_i <= 1'b0;
        expect_err(MAIN_STATE, SUB_WDT);
        // second power-on with a bad ones digit
        @(posedge clock_i);
        reset_i <= 1'b1;
        node_tens_i <= 4'h0;
        node_ones_i <= 4'hA;
        repeat (2) @(posedge clock_i);
        chk("comm_state_o", 8'h01, {4'h0, comm_state_o});
        reset_i <= 1'b0;
        expect_err(MAIN_NODE, SUB_NONE);
        stop_test();
    end
endmodule
